// file: rtc_control_status_irq.sv
// Control and status registers of the clock with its interrupt output logic.
module rtc_control_status_irq #(
    parameter int WIDTH_8192 = rtc_ctrl_pkg::CYC_8192,
    parameter int WIDTH_4096 = rtc_ctrl_pkg::CYC_4096,
    parameter int WIDTH_128  = rtc_ctrl_pkg::CYC_128,
    parameter int WIDTH_64   = rtc_ctrl_pkg::CYC_64
) (
    // Clock and reset
    input  wire logic                              i_clk,
    input  wire logic                              i_nrst,
    // Register access from the serial bus engine
    input  wire logic                              i_wr_en,
    input  wire logic                              i_rd_en,
    input  wire logic [rtc_ctrl_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [rtc_ctrl_pkg::DATA_W-1:0]   i_wr_data,
    output logic      [rtc_ctrl_pkg::DATA_W-1:0]   o_rd_data,
    output logic                                   o_rd_valid,
    output logic                                   o_rd_hit,
    // Events from alarm comparator and countdown timer
    input  wire logic                              i_alarm_event,
    input  wire logic                              i_timer_event,
    input  wire logic [1:0]                        i_timer_src,
    input  wire logic                              i_timer_count_one,
    // Control outputs to the rest of the device
    output logic                                   o_ext_clock_test_select,
    output logic                                   o_rtc_halt,
    output logic                                   o_divider_clear_n,
    output logic                                   o_por_override_enable,
    // Open-drain interrupt pin
    output logic                                   o_int_n_out,
    output logic                                   o_int_n_oe
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    localparam int CNT_W = rtc_ctrl_pkg::PULSE_CNT_W;

    if (WIDTH_8192 < 1 || WIDTH_4096 < 1 || WIDTH_128 < 1 ||
        WIDTH_64 < 1) begin : g_bad_width
        $error("Pulse widths must be at least one cycle.");
    end
    if (WIDTH_8192 >= (1 << CNT_W) || WIDTH_4096 >= (1 << CNT_W) ||
        WIDTH_128 >= (1 << CNT_W) || WIDTH_64 >= (1 << CNT_W))
    begin : g_wide_width
        $error("Pulse widths do not fit the pulse counter.");
    end

    localparam logic [CNT_W-1:0] W_8192 = CNT_W'(WIDTH_8192);
    localparam logic [CNT_W-1:0] W_4096 = CNT_W'(WIDTH_4096);
    localparam logic [CNT_W-1:0] W_128  = CNT_W'(WIDTH_128);
    localparam logic [CNT_W-1:0] W_64   = CNT_W'(WIDTH_64);

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic addr_is(
        input logic [rtc_ctrl_pkg::ADDR_W-1:0] addr,
        input logic [rtc_ctrl_pkg::ADDR_W-1:0] target
    );
        addr_is = (addr == target);
    endfunction

    logic wr_one;
    logic wr_two;
    logic rd_one;
    logic rd_two;

    assign wr_one = i_wr_en && addr_is(i_addr, rtc_ctrl_pkg::CTRL_ONE_ADDR);
    assign wr_two = i_wr_en && addr_is(i_addr, rtc_ctrl_pkg::CTRL_TWO_ADDR);
    assign rd_one = i_rd_en && addr_is(i_addr, rtc_ctrl_pkg::CTRL_ONE_ADDR);
    assign rd_two = i_rd_en && addr_is(i_addr, rtc_ctrl_pkg::CTRL_TWO_ADDR);

    // ************************************************************
    // Control register one
    // ************************************************************
    logic ext_test_q;
    logic halt_q;
    logic por_ovr_q;

    // Unused positions are not stored.
    // see (RULE4)
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_test_q <= rtc_ctrl_pkg::CTRL_ONE_RST[rtc_ctrl_pkg::EXT_TEST_BIT];
        end else if (wr_one) begin
            ext_test_q <= i_wr_data[rtc_ctrl_pkg::EXT_TEST_BIT]; // see (RULE1)
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            halt_q <= rtc_ctrl_pkg::CTRL_ONE_RST[rtc_ctrl_pkg::HALT_BIT];
        end else if (wr_one) begin
            halt_q <= i_wr_data[rtc_ctrl_pkg::HALT_BIT]; // see (RULE2)
        end
    end

    // Override enable comes up set.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            por_ovr_q <= rtc_ctrl_pkg::CTRL_ONE_RST[rtc_ctrl_pkg::POR_OVR_BIT]; // see (RULE19)
        end else if (wr_one) begin
            por_ovr_q <= i_wr_data[rtc_ctrl_pkg::POR_OVR_BIT]; // see (RULE3)
        end
    end

    assign o_ext_clock_test_select = ext_test_q;
    assign o_por_override_enable   = por_ovr_q;

    // The divider clear is a plain level from halt.
    // The chain stays cleared while halt is set.
    // The square-wave path is not touched here.
    assign o_rtc_halt        = halt_q; // see (RULE2)
    assign o_divider_clear_n = ~halt_q;

    // ************************************************************
    // Control register two: modes and enables
    // ************************************************************
    logic pulse_sel_q;
    logic pulse_sel_d;
    logic aie_q;
    logic aie_d;
    logic tie_q;
    logic tie_d;

    always_comb begin
        pulse_sel_d = pulse_sel_q;
        aie_d       = aie_q;
        tie_d       = tie_q;
        if (wr_two) begin
            pulse_sel_d = i_wr_data[rtc_ctrl_pkg::PULSE_SEL_BIT];
            aie_d       = i_wr_data[rtc_ctrl_pkg::AIE_BIT]; // see (RULE13)
            tie_d       = i_wr_data[rtc_ctrl_pkg::TIE_BIT]; // see (RULE13)
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pulse_sel_q <= rtc_ctrl_pkg::CTRL_TWO_RST[rtc_ctrl_pkg::PULSE_SEL_BIT];
        end else begin
            pulse_sel_q <= pulse_sel_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            aie_q <= rtc_ctrl_pkg::CTRL_TWO_RST[rtc_ctrl_pkg::AIE_BIT];
            tie_q <= rtc_ctrl_pkg::CTRL_TWO_RST[rtc_ctrl_pkg::TIE_BIT];
        end else begin
            aie_q <= aie_d;
            tie_q <= tie_d;
        end
    end

    // ************************************************************
    // Alarm and timer flags
    // ************************************************************
    logic aflag_q;
    logic aflag_d;
    logic tflag_q;
    logic tflag_d;

    // A write ANDs into the flag, so a one keeps it;
    // an event in the same cycle wins over the clear.
    always_comb begin
        aflag_d = aflag_q;
        if (wr_two) begin
            aflag_d = aflag_q & i_wr_data[rtc_ctrl_pkg::AFLAG_BIT]; // see (RULE8)
        end
        if (i_alarm_event) begin
            aflag_d = 1'b1; // see (RULE10)
        end
    end

    always_comb begin
        tflag_d = tflag_q;
        if (wr_two) begin
            tflag_d = tflag_q & i_wr_data[rtc_ctrl_pkg::TFLAG_BIT]; // see (RULE9)
        end
        if (i_timer_event) begin
            tflag_d = 1'b1; // see (RULE11)
        end
    end

    // Nothing but a register write or reset lowers a flag. see (RULE12)
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            aflag_q <= rtc_ctrl_pkg::CTRL_TWO_RST[rtc_ctrl_pkg::AFLAG_BIT];
        end else begin
            aflag_q <= aflag_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tflag_q <= rtc_ctrl_pkg::CTRL_TWO_RST[rtc_ctrl_pkg::TFLAG_BIT];
        end else begin
            tflag_q <= tflag_d;
        end
    end

    // ************************************************************
    // Pulse width selection
    // ************************************************************
    logic [CNT_W-1:0] pulse_width;
    rtc_ctrl_pkg::timer_src_e src;

    assign src = rtc_ctrl_pkg::timer_src_e'(i_timer_src);

    // Slow sources share one width: the pulse clock
    // bottoms out at a 64th of a second. see (RULE16)
    always_comb begin
        pulse_width = W_64;
        unique case (src)
            rtc_ctrl_pkg::SRC_4096_HZ: begin
                pulse_width = i_timer_count_one ? W_8192 : W_4096;
            end
            rtc_ctrl_pkg::SRC_64_HZ: begin
                pulse_width = i_timer_count_one ? W_128 : W_64;
            end
            rtc_ctrl_pkg::SRC_1_HZ: begin
                pulse_width = W_64;
            end
            rtc_ctrl_pkg::SRC_1_60TH_HZ: begin
                pulse_width = W_64;
            end
        endcase
    end

    // ************************************************************
    // Pulsed timer interrupt
    // ************************************************************
    logic pulse_start;
    logic pulse_active;
    logic pulse_active_d;

    // Pulses start only in pulsed mode with the timer enabled.
    assign pulse_start = i_timer_event && pulse_sel_q && tie_q; // see (RULE6)

    rtc_irq_pulse #(
        .CNT_W      (CNT_W)
    ) u_pulse (
        .i_clk      (i_clk),
        .i_nrst     (i_nrst),
        .i_start    (pulse_start),
        .i_width    (pulse_width),
        .o_active   (pulse_active),
        .o_active_d (pulse_active_d)
    );

    // ************************************************************
    // Interrupt combine
    // ************************************************************
    logic alarm_cond_d;
    logic timer_cond_d;
    logic irq_d;
    logic irq_q;

    // Built from next-state values so that the pin and the timer flag
    // move on the same clock edge.
    assign alarm_cond_d = aflag_d && aie_d; // see (RULE7)
    assign timer_cond_d = tie_d && (pulse_sel_d ? pulse_active_d // see (RULE6)
                                                : tflag_d);      // see (RULE5)
    assign irq_d        = alarm_cond_d || timer_cond_d; // see (RULE14)

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d; // see (RULE17)
        end
    end

    // The pin is only ever pulled low; with both enables clear irq_q
    // stays low and the pin stays released. see (RULE15)
    assign o_int_n_out = 1'b0; // see (RULE18)
    assign o_int_n_oe  = irq_q; // see (RULE18)

    // ************************************************************
    // Read path
    // ************************************************************
    logic [rtc_ctrl_pkg::DATA_W-1:0] ctrl_one_val;
    logic [rtc_ctrl_pkg::DATA_W-1:0] ctrl_two_val;
    logic [rtc_ctrl_pkg::DATA_W-1:0] rd_data_q;
    logic                            rd_valid_q;
    logic                            rd_hit_q;

    always_comb begin
        ctrl_one_val = '0;
        ctrl_one_val[rtc_ctrl_pkg::EXT_TEST_BIT] = ext_test_q;
        ctrl_one_val[rtc_ctrl_pkg::HALT_BIT]     = halt_q;
        ctrl_one_val[rtc_ctrl_pkg::POR_OVR_BIT]  = por_ovr_q;
    end

    always_comb begin
        ctrl_two_val = '0;
        ctrl_two_val[rtc_ctrl_pkg::PULSE_SEL_BIT] = pulse_sel_q;
        ctrl_two_val[rtc_ctrl_pkg::AFLAG_BIT]     = aflag_q;
        ctrl_two_val[rtc_ctrl_pkg::TFLAG_BIT]     = tflag_q;
        ctrl_two_val[rtc_ctrl_pkg::AIE_BIT]       = aie_q;
        ctrl_two_val[rtc_ctrl_pkg::TIE_BIT]       = tie_q;
    end

    // Read data lands one cycle after the request; other
    // addresses read zero with the hit flag low.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_data_q <= '0;
        end else if (rd_one) begin
            rd_data_q <= ctrl_one_val & rtc_ctrl_pkg::CTRL_ONE_MASK;
        end else if (rd_two) begin
            rd_data_q <= ctrl_two_val & rtc_ctrl_pkg::CTRL_TWO_MASK;
        end else if (i_rd_en) begin
            rd_data_q <= '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_valid_q <= 1'b0;
            rd_hit_q   <= 1'b0;
        end else begin
            rd_valid_q <= i_rd_en;
            rd_hit_q   <= rd_one || rd_two;
        end
    end

    assign o_rd_data  = rd_data_q;
    assign o_rd_valid = rd_valid_q;
    assign o_rd_hit   = rd_hit_q;

endmodule

// file: rtc_control_status_irq_asserts.sv
// Checker of the control outputs and interrupt pin of the clock block.
module rtc_control_status_irq_asserts #(
    parameter int WIDTH_64   = 5
) (
    input wire logic                            i_clk,
    input wire logic                            i_nrst,
    input wire logic                            i_wr_en,
    input wire logic [rtc_ctrl_pkg::ADDR_W-1:0] i_addr,
    input wire logic [rtc_ctrl_pkg::DATA_W-1:0] i_wr_data,
    input wire logic                            i_alarm_event,
    input wire logic                            i_timer_event,
    input wire logic                            o_ext_clock_test_select,
    input wire logic                            o_rtc_halt,
    input wire logic                            o_divider_clear_n,
    input wire logic                            o_por_override_enable,
    input wire logic                            o_int_n_out,
    input wire logic                            o_int_n_oe
);
    // ************************************************************
    // Shadow of the enables and pulse select, kept from observed writes
    // ************************************************************
    logic        tie_q;
    logic        aie_q;
    logic        pulse_q;
    logic [20:0] run_q;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tie_q   <= 1'b0;
            aie_q   <= 1'b0;
            pulse_q <= 1'b0;
        end else if (i_wr_en && i_addr == rtc_ctrl_pkg::CTRL_TWO_ADDR) begin
            tie_q   <= i_wr_data[0];
            aie_q   <= i_wr_data[1];
            pulse_q <= i_wr_data[4];
        end
    end

    // Length of the current pin assertion; only pulsed runs are counted.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            run_q <= '0;
        end else if (i_timer_event || !pulse_q || aie_q || !o_int_n_oe) begin
            run_q <= '0;
        end else begin
            run_q <= run_q + 21'h1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence wr_one;
        i_wr_en && i_addr == rtc_ctrl_pkg::CTRL_ONE_ADDR;
    endsequence

    sequence alarm_armed;
        i_alarm_event && aie_q && !i_wr_en;
    endsequence

    property p_follow(int b, logic o);
        logic d;
        (wr_one, d = i_wr_data[b]) |=> o == d;
    endproperty

    a_test_follows_write: assert property (p_follow(7, o_ext_clock_test_select))
        else $error("test select missed write");
    a_halt_follows_write: assert property (p_follow(5, o_rtc_halt))
        else $error("halt did not follow write");
    a_por_follows_write: assert property (p_follow(3, o_por_override_enable))
        else $error("override missed write");
    a_clear_tracks_halt: assert property (o_divider_clear_n == !o_rtc_halt)
        else $error("divider clear disagrees with halt");
    a_int_drives_low: assert property (o_int_n_oe |-> o_int_n_out == 1'b0)
        else $error("interrupt pin driven high");
    a_int_released_idle: assert property ((!tie_q && !aie_q)[*2] |-> !o_int_n_oe)
        else $error("interrupt with enables clear");
    a_timer_sets_int: assert property (i_timer_event && tie_q && !i_wr_en |=> o_int_n_oe)
        else $error("timer end gave no interrupt");
    a_alarm_holds_int: assert property (alarm_armed ##1 !i_wr_en[*3] |-> o_int_n_oe)
        else $error("alarm interrupt not held");
    a_pulse_width_bound: assert property (pulse_q && !aie_q |-> run_q <= WIDTH_64)
        else $error("timer pulse too long");
endmodule

bind rtc_control_status_irq rtc_control_status_irq_asserts #(
    .WIDTH_64(WIDTH_64)
) rtc_control_status_irq_asserts_inst (
    .i_clk, .i_nrst, .i_wr_en, .i_addr, .i_wr_data, .i_alarm_event,
    .i_timer_event, .o_ext_clock_test_select, .o_rtc_halt,
    .o_divider_clear_n, .o_por_override_enable, .o_int_n_out, .o_int_n_oe
);

// file: rtc_control_status_irq_tb.sv
// Self-checking bench of the control registers and interrupt logic.
module rtc_control_status_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int W8192 = 2;
    localparam int W4096 = 3;
    localparam int W128  = 4;
    localparam int W64   = 5;

    logic       i_clk = 1'b0;
    logic       i_nrst = 1'b0;
    logic       wr_en, rd_en, rd_valid, rd_hit;
    logic [7:0] addr, wr_data, rd_data;
    logic       i_alarm_event = 1'b0;
    logic       i_timer_event = 1'b0;
    logic [1:0] i_timer_src = 2'b00;
    logic       i_timer_count_one = 1'b0;
    logic       ext_test, halt, clear_n, por_en, int_out, int_oe;
    int         n_mismatch = 0;
    int         comparisons = 0;
    int         c1_m = 8;
    int         c2_m = 0;
    int         cnt;
    logic [7:0] d;

    always #5 i_clk = ~i_clk;

    rtc_host_model rtc_host_model_inst (
        .i_clk(i_clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
        .o_wr_data(wr_data), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
        .i_rd_hit(rd_hit)
    );

    rtc_control_status_irq #(
        .WIDTH_8192(W8192), .WIDTH_4096(W4096),
        .WIDTH_128(W128), .WIDTH_64(W64)
    ) rtc_control_status_irq_inst (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wr_data(wr_data), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_rd_hit(rd_hit),
        .i_alarm_event(i_alarm_event), .i_timer_event(i_timer_event),
        .i_timer_src(i_timer_src), .i_timer_count_one(i_timer_count_one),
        .o_ext_clock_test_select(ext_test), .o_rtc_halt(halt),
        .o_divider_clear_n(clear_n), .o_por_override_enable(por_en),
        .o_int_n_out(int_out), .o_int_n_oe(int_oe)
    );

    // ************************************************************
    // Compare, model and stimulus helpers
    // ************************************************************
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Unless raw, the host keeps unused and test bits at zero.
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input bit raw);
        if (!raw) v = v & ((a == 8'h00) ? 8'h28 : 8'h1F);
        rtc_host_model_inst.write_reg(a, v);
        if (a == 8'h00) c1_m = v & 8'hA8;
        if (a == 8'h01) c2_m = (v & 8'h13) | (v & c2_m & 8'h0C);
    endtask

    task automatic rd_chk(input logic [7:0] a);
        logic [7:0] v;
        logic       h;
        rtc_host_model_inst.read_reg(a, v, h);
        check("read data", v, (a == 8'h00) ? 8'(c1_m) :
              (a == 8'h01) ? 8'(c2_m) : 8'h00);
        check("read hit", 8'(h), 8'(a <= 8'h01));
    endtask

    task automatic event_pulse(input bit timer);
        @(posedge i_clk);
        if (timer) i_timer_event <= 1'b1;
        else i_alarm_event <= 1'b1;
        @(posedge i_clk);
        i_timer_event <= 1'b0;
        i_alarm_event <= 1'b0;
        #1;
        c2_m = c2_m | (timer ? 4 : 8);
    endtask

    function automatic logic [7:0] level_int();
        return 8'((c2_m[2] & c2_m[0]) | (c2_m[3] & c2_m[1]));
    endfunction

    function automatic int exp_width(int s, int n);
        if (s == 0) return n ? W8192 : W4096;
        if (s == 1) return n ? W128 : W64;
        return W64;
    endfunction

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        void'($urandom(32'h114B));
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        rd_chk(8'h00);
        rd_chk(8'h01);
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? 8'hFF : 8'($urandom);
            wr(8'h00, d, 1'b1);
            rd_chk(8'h00);
            check("test select", 8'(ext_test), 8'(c1_m[7]));
            check("halt", 8'(halt), 8'(c1_m[5]));
            check("clear", 8'(clear_n), 8'(!c1_m[5]));
            check("override", 8'(por_en), 8'(c1_m[3]));
        end
        wr(8'h00, 8'h08, 1'b0);
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 8'h02 : 8'($urandom_range(255, 2));
            wr(d, 8'hFF, 1'b1);
            rd_chk(d);
        end
        wr(8'h01, 8'h03, 1'b0);
        event_pulse(1'b0);
        check("int alarm", 8'(int_oe), level_int());
        event_pulse(1'b1);
        check("int both", 8'(int_oe), level_int());
        repeat (10) @(posedge i_clk);
        rd_chk(8'h01);
        for (int e = 0; e < 4; e++) begin
            wr(8'h01, 8'h0C | 8'(e), 1'b0);
            #1;
            check("int level", 8'(int_oe), level_int());
            rd_chk(8'h01);
        end
        wr(8'h01, 8'h0B, 1'b0);
        rd_chk(8'h01);
        wr(8'h01, 8'h07, 1'b0);
        rd_chk(8'h01);
        wr(8'h01, 8'h11, 1'b0);
        for (int s = 0; s < 4; s++) begin
            for (int n = 0; n < 2; n++) begin
                i_timer_src <= 2'(s);
                i_timer_count_one <= 1'(n);
                event_pulse(1'b1);
                cnt = 0;
                repeat (12) begin
                    if (int_oe === 1'b1) cnt++;
                    @(posedge i_clk);
                    #1;
                end
                check("pulse width", 8'(cnt), 8'(exp_width(s, n)));
                rd_chk(8'h01);
            end
        end
        wr(8'h01, 8'h10, 1'b0);
        event_pulse(1'b1);
        check("int no enable", 8'(int_oe), 8'h00);
        rd_chk(8'h01);
        wr(8'h01, 8'h12, 1'b0);
        event_pulse(1'b0);
        repeat (20) @(posedge i_clk);
        #1;
        check("int held", 8'(int_oe), 8'h01);
        i_nrst <= 1'b0;
        @(posedge i_clk);
        i_nrst <= 1'b1;
        c1_m = 8;
        c2_m = 0;
        rd_chk(8'h00);
        rd_chk(8'h01);
        check("int reset", 8'(int_oe), 8'h00);
        tally_and_finish();
    end

    // Run is near two hundred fifty cycles.
    initial begin
        #300_000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule

// file: rtc_ctrl_pkg.sv
// Package of register map, field layout, reset values and timing counts.
// Summary of operation
// (RULE1) Control one bit 7 selects external clock test; resets to zero.
// (RULE2) Halt bit 5 clears divider chain, stops RTC; square wave runs on.
// (RULE3) Control one bit 3 enables power-on-reset override; default one.
// (RULE4) Host writes zero to unused bits of both control registers.
// (RULE5) Pulse select zero: interrupt is timer flag level, gated by enable.
// (RULE6) Pulse select one: interrupt pulses per countdown end, gated.
// (RULE7) Alarm flag with alarm enable holds interrupt, even when pulsed.
// (RULE8) Alarm flag bit 3: write zero clears, write one keeps.
// (RULE9) Timer flag bit 2: write zero clears, write one keeps.
// (RULE10) Alarm condition sets the alarm flag.
// (RULE11) Countdown end sets the timer flag.
// (RULE12) Flags hold until the host overwrites them.
// (RULE13) Alarm enable bit 1, timer enable bit 0; both reset disabled.
// (RULE14) Interrupt is OR of the enabled alarm and timer conditions.
// (RULE15) With both enables clear, the interrupt pin stays released.
// (RULE16) Pulse width depends on timer source clock and count one.
// (RULE17) Pulsed: timer flag and interrupt assert at the same edge.
// (RULE18) Interrupt is active low open drain, driven low when asserted.
// (RULE19) Reset: control one holds only override enable; control two zero.
package rtc_ctrl_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    localparam logic [7:0]  CTRL_ONE_ADDR = 8'h00;
    localparam logic [7:0]  CTRL_TWO_ADDR = 8'h01;

    // Control one fields.
    localparam int          EXT_TEST_BIT  = 7;
    localparam int          HALT_BIT      = 5;
    localparam int          POR_OVR_BIT   = 3;
    localparam logic [7:0]  CTRL_ONE_MASK = 8'hA8;
    localparam logic [7:0]  CTRL_ONE_RST  = 8'h08;

    // Control two fields.
    localparam int          PULSE_SEL_BIT = 4;
    localparam int          AFLAG_BIT     = 3;
    localparam int          TFLAG_BIT     = 2;
    localparam int          AIE_BIT       = 1;
    localparam int          TIE_BIT       = 0;
    localparam logic [7:0]  CTRL_TWO_MASK = 8'h1F;
    localparam logic [7:0]  CTRL_TWO_RST  = 8'h00;

    // ************************************************************
    // Timer source clock selection
    // ************************************************************
    typedef enum logic [1:0] {
        SRC_4096_HZ   = 2'b00,
        SRC_64_HZ     = 2'b01,
        SRC_1_HZ      = 2'b10,
        SRC_1_60TH_HZ = 2'b11
    } timer_src_e;

    // ************************************************************
    // Pulse widths, given as reciprocal seconds, and cycle counts
    // ************************************************************
    localparam int CLK_HZ        = 100_000_000;
    localparam int PULSE_HZ_8192 = 8192;
    localparam int PULSE_HZ_4096 = 4096;
    localparam int PULSE_HZ_128  = 128;
    localparam int PULSE_HZ_64   = 64;
    localparam int CYC_8192      = CLK_HZ / PULSE_HZ_8192;
    localparam int CYC_4096      = CLK_HZ / PULSE_HZ_4096;
    localparam int CYC_128       = CLK_HZ / PULSE_HZ_128;
    localparam int CYC_64        = CLK_HZ / PULSE_HZ_64;
    localparam int PULSE_CNT_W   = 21;

endpackage

// file: rtc_host_model.sv
// Host side model issuing single byte register accesses.
module rtc_host_model (
    // Clock
    input  wire logic       i_clk,
    // Register access
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wr_data,
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_valid,
    input  wire logic       i_rd_hit
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_wr_en   = 1'b0;
        o_rd_en   = 1'b0;
        o_addr    = 8'hFF;
        o_wr_data = 8'h00;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr_en   <= 1'b1;
        o_addr    <= a;
        o_wr_data <= d;
        @(posedge i_clk);
        o_wr_en   <= 1'b0;
        o_addr    <= ~a;
        o_wr_data <= ~d;
    endtask

    // No answer gives an unknown hit.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic hit);
        @(posedge i_clk);
        o_rd_en <= 1'b1;
        o_addr  <= a;
        @(posedge i_clk);
        o_rd_en <= 1'b0;
        o_addr  <= ~a;
        #1;
        hit = (i_rd_valid === 1'b1) ? i_rd_hit : 1'bx;
        d   = i_rd_data;
    endtask
endmodule

// file: rtc_irq_pulse.sv
// Pulse stretcher that times the pulsed timer interrupt.
module rtc_irq_pulse #(
    parameter int CNT_W = rtc_ctrl_pkg::PULSE_CNT_W
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    // Control
    input  wire logic             i_start,
    input  wire logic [CNT_W-1:0] i_width,
    // Status
    output logic                  o_active,
    output logic                  o_active_d
);

    // ************************************************************
    // Width counter
    // ************************************************************
    logic [CNT_W-1:0] remain_q;
    logic [CNT_W-1:0] remain_d;

    always_comb begin
        remain_d = remain_q;
        if (i_start) begin
            remain_d = i_width;
        end else if (remain_q != '0) begin
            remain_d = remain_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // A new countdown end restarts the pulse rather than stacking on it.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            remain_q <= '0;
        end else begin
            remain_q <= remain_d;
        end
    end

    assign o_active_d = (remain_d != '0);
    assign o_active   = (remain_q != '0);

endmodule
